// File: design/adcs_pkg.sv
// Shared constants and types of the converter sequencer
package adcs_pkg;

  // ************************************************
  // Processor ports
  // ************************************************
  localparam int PORT_CNT = 16;
  localparam int DATA_W = 16;
  localparam logic [3:0] PORT_MOD_ADDR = 4'hD;
  localparam logic [3:0] PORT_MOD_DATA_LO = 4'hE;
  localparam logic [3:0] PORT_MOD_DATA_HI = 4'hF;
  localparam int MOD_ID_LSB = 4;
  localparam logic [3:0] MOD_ID_POWER = 4'h0;
  localparam logic [3:0] MOD_ID_ADC = 4'h1;

  // ************************************************
  // Converter register indices
  // ************************************************
  localparam logic [3:0] REG_CONV_CTRL = 4'h0;
  localparam logic [3:0] REG_CHAN_BASE = 4'h1;
  localparam logic [3:0] REG_CHAN_STRIDE = 4'h3;
  localparam logic [3:0] REG_OFS_SETUP_A = 4'h0;
  localparam logic [3:0] REG_OFS_SETUP_B = 4'h1;
  localparam logic [3:0] REG_OFS_RESULT = 4'h2;
  localparam logic [3:0] REG_POWER_CTRL = 4'h0;
  localparam int CHAN_CNT = 3;

  // ************************************************
  // Field positions
  // ************************************************
  localparam int CTRL_START_LSB = 0;
  localparam int CTRL_SE_LSB = 4;
  localparam int SETUP_A_GAIN_LSB = 0;
  localparam int SETUP_A_RES_LSB = 4;
  localparam int SETUP_B_BIAS_LSB = 0;
  localparam int SETUP_B_REF_LSB = 3;
  localparam int SETUP_B_PRESC_LSB = 7;
  localparam int PWR_ADC_BIT = 0;

  // ************************************************
  // Reset values
  // ************************************************
  localparam logic [15:0] SETUP_RST = 16'h0000;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] POWER_RST = 16'h0000;

  // ************************************************
  // Timing
  // ************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int POR_HOLD_NS = 250000;
  localparam int POR_HOLD_CYC = (POR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] CONV_BASE_CLKS = 16'h0010;
  localparam int PRESC_MIN_DIV = 4;
  localparam int PRESC_MAX_DIV = 512;

  // ************************************************
  // Codes
  // ************************************************
  localparam logic [1:0] CH_ONE = 2'h0;
  localparam logic [1:0] CH_TWO = 2'h1;
  localparam logic [1:0] CH_TEMP = 2'h2;
  localparam logic [1:0] REF_SUPPLY = 2'h0;
  localparam logic [1:0] REF_EXT_PIN = 2'h1;
  localparam logic [1:0] REF_BANDGAP_X4 = 2'h2;
  localparam logic [1:0] REF_BANDGAP = 2'h3;
  localparam logic [1:0] GAIN_PROG = 2'h0;
  localparam logic [1:0] GAIN_FIX_094 = 2'h1;
  localparam logic [1:0] GAIN_FIX_070 = 2'h2;
  localparam logic [3:0] SE_NONE = 4'h0;
  localparam logic [3:0] SE_FIX_094_MIN = 4'h8;
  localparam logic [3:0] SE_FIX_070_MIN = 4'hC;
  localparam logic [1:0] DBG_ACC = 2'h0;
  localparam logic [1:0] DBG_PTR = 2'h1;
  localparam logic [1:0] DBG_INSTR = 2'h2;

  // ************************************************
  // Types
  // ************************************************
  typedef enum logic [2:0] {
    ST_POR = 3'b001,
    ST_IDLE = 3'b010,
    ST_CONV = 3'b100
  } adcs_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] idx;
    logic [15:0] wdata;
  } adcs_port_req_t;

  typedef struct packed {
    logic [15:0] acc;
    logic [15:0] ptr;
    logic [15:0] instr;
  } adcs_dbg_t;

  typedef struct packed {
    logic power;
    logic [1:0] chan;
    logic [1:0] ref_sel;
    logic [1:0] gain_mode;
    logic [3:0] gain_code;
    logic [3:0] se_sel;
    logic [2:0] bias;
  } adcs_afe_ctl_t;

endpackage

// File: design/adcs_prescaler.sv
// Converter clock prescaler
`timescale 1ns/1ps
`default_nettype none

module adcs_prescaler
  import adcs_pkg::*;
#(
  parameter int DIV_W = 9
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic [DIV_W-1:0] div_m1_i,
  output logic tick_o,
  output logic conv_clk_o
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
    logic clk;
  } adcs_presc_state_t;

  adcs_presc_state_t r;
  adcs_presc_state_t n;
  logic [DIV_W-1:0] div_lim;

  initial begin
    if (DIV_W < 2 || (1 << DIV_W) < PRESC_MAX_DIV) begin
      $error("adcs_prescaler: DIV_W too small for the divisor range");
    end
  end

  // ************************************************
  // Divider
  // ************************************************
  always_comb begin
    n = r;
    // Divisors below the minimum are raised to it
    div_lim = (div_m1_i < DIV_W'(PRESC_MIN_DIV - 1)) ? DIV_W'(PRESC_MIN_DIV - 1) : div_m1_i;
    n.tick = 1'b0;
    if (!run_i) begin
      n.cnt = '0;
      n.clk = 1'b0;
    end else if (r.cnt == div_lim) begin
      n.cnt = '0;
      n.tick = 1'b1;
      n.clk = 1'b0;
    end else begin
      n.cnt = r.cnt + DIV_W'(1);
      if (r.cnt == (div_lim >> 1)) begin
        n.clk = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tick_o = r.tick;
  assign conv_clk_o = r.clk;

endmodule // adcs_prescaler

`default_nettype wire

// File: design/adcs_sequencer.sv
// Converter conversion sequencer with processor port access and power-on hold
`timescale 1ns/1ps
`default_nettype none

module adcs_sequencer
  import adcs_pkg::*;
#(
  parameter int POR_HOLD_CYCLES = POR_HOLD_CYC,
  parameter int PRESC_W = 9
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire adcs_port_req_t port_req_i,
  input wire adcs_dbg_t dbg_i,
  input wire logic [1:0] dbg_sel_i,
  input wire logic [15:0] conv_data_i,
  output logic [15:0] port_rdata_o,
  output logic [15:0] dbg_word_o,
  output logic cpu_halt_o,
  output logic cpu_run_o,
  output adcs_afe_ctl_t afe_ctl_o,
  output logic conv_clk_o
);

  initial begin
    if (POR_HOLD_CYCLES < 1 || POR_HOLD_CYCLES > 65535) begin
      $error("adcs_sequencer: POR_HOLD_CYCLES out of range");
    end
    if (PRESC_W != 9) begin
      $error("adcs_sequencer: PRESC_W must match the setup field");
    end
  end

  // ************************************************
  // State
  // ************************************************
  typedef struct packed {
    adcs_state_t state;
    logic [15:0] por_cnt;
    logic [PORT_CNT-1:0][15:0] ports;
    logic [15:0] ctrl;
    logic [15:0] power;
    logic [CHAN_CNT-1:0][15:0] setup_a;
    logic [CHAN_CNT-1:0][15:0] setup_b;
    logic [CHAN_CNT-1:0][15:0] result;
    logic [15:0] conv_cnt;
    logic [2:0] res;
    logic [15:0] rdata;
    logic [15:0] dbg;
    logic halt;
    logic run;
    adcs_afe_ctl_t afe;
    logic [15:0] data_meta;
    logic [15:0] data_sync;
  } adcs_seq_state_t;

  localparam adcs_seq_state_t SEQ_RST = '{state: ST_POR, default: '0};

  adcs_seq_state_t r;
  adcs_seq_state_t n;
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic presc_tick;
  logic presc_run;
  logic [PRESC_W-1:0] presc_div_m1;

  // ************************************************
  // Reset release
  // ************************************************
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_r[1];

  // ************************************************
  // Helpers
  // ************************************************
  // Lowest resolution code needs the fewest clocks; each bias step below 7 adds one base period
  function automatic logic [15:0] conv_clocks(input logic [2:0] res, input logic [2:0] bias);
    logic [15:0] base;
    base = 16'(CONV_BASE_CLKS << res);
    conv_clocks = 16'(base * (16'(7) - 16'(bias) + 16'(1)));
  endfunction

  // Bits below the chosen resolution read as zero, sign stays at bit 15
  function automatic logic [15:0] res_mask(input logic [2:0] res);
    res_mask = 16'(16'hFFFF << (3'd7 - res));
  endfunction

  function automatic logic [3:0] reg_idx(input int chan, input logic [3:0] ofs);
    reg_idx = 4'(REG_CHAN_BASE + 4'(chan) * REG_CHAN_STRIDE + ofs);
  endfunction

  // ************************************************
  // Next state
  // ************************************************
  logic [15:0] mod_addr;
  logic [3:0] mod_id;
  logic [3:0] mod_reg;
  logic [15:0] mod_rword;
  logic [2:0] start_req;
  logic [1:0] sel_chan;
  logic [3:0] se_code;
  logic [15:0] wword;
  logic acc_ok;

  always_comb begin
    n = r;
    mod_addr = r.ports[PORT_MOD_ADDR];
    mod_id = mod_addr[MOD_ID_LSB +: 4];
    mod_reg = mod_addr[3:0];
    wword = port_req_i.wdata;
    start_req = wword[CTRL_START_LSB +: 3];
    se_code = wword[CTRL_SE_LSB +: 4];
    sel_chan = CH_ONE;
    acc_ok = r.run && !r.halt;

    // Two-stage capture of the front-end result word
    n.data_meta = conv_data_i;
    n.data_sync = r.data_meta;

    // Module readback through the data-high port
    mod_rword = 16'h0000;
    if (mod_id == MOD_ID_POWER && mod_reg == REG_POWER_CTRL) begin
      mod_rword = r.power;
    end else if (mod_id == MOD_ID_ADC) begin
      if (mod_reg == REG_CONV_CTRL) begin
        mod_rword = r.ctrl;
      end
      for (int c = 0; c < CHAN_CNT; c++) begin
        if (mod_reg == reg_idx(c, REG_OFS_SETUP_A)) begin
          mod_rword = r.setup_a[c];
        end
        if (mod_reg == reg_idx(c, REG_OFS_SETUP_B)) begin
          mod_rword = r.setup_b[c];
        end
        if (mod_reg == reg_idx(c, REG_OFS_RESULT)) begin
          mod_rword = r.result[c];
        end
      end
    end

    // Debug words only visible while halted
    n.dbg = 16'h0000;
    if (r.halt) begin
      case (dbg_sel_i)
        DBG_ACC: begin
          n.dbg = dbg_i.acc;
        end
        DBG_PTR: begin
          n.dbg = dbg_i.ptr;
        end
        DBG_INSTR: begin
          n.dbg = dbg_i.instr;
        end
        default: begin
          n.dbg = 16'h0000;
        end
      endcase
    end

    case (r.state)
      ST_POR: begin
        if (r.por_cnt == 16'(POR_HOLD_CYCLES - 1)) begin
          n.state = ST_IDLE;
          n.run = 1'b1;
        end else begin
          n.por_cnt = r.por_cnt + 16'h0001;
        end
      end

      ST_IDLE: begin
        // Accesses ignored until the processor runs
        if (acc_ok && port_req_i.rd) begin
          if (port_req_i.idx == PORT_MOD_DATA_HI) begin
            n.rdata = mod_rword;
          end else begin
            n.rdata = r.ports[port_req_i.idx];
          end
        end
        if (acc_ok && port_req_i.wr) begin
          n.ports[port_req_i.idx] = wword;
          if (port_req_i.idx == PORT_MOD_DATA_LO) begin
            if (mod_id == MOD_ID_POWER && mod_reg == REG_POWER_CTRL) begin
              n.power = wword;
            end else if (mod_id == MOD_ID_ADC) begin
              for (int c = 0; c < CHAN_CNT; c++) begin
                if (mod_reg == reg_idx(c, REG_OFS_SETUP_A)) begin
                  n.setup_a[c] = wword;
                end
                if (mod_reg == reg_idx(c, REG_OFS_SETUP_B)) begin
                  n.setup_b[c] = wword;
                end
              end
              // Result registers are read only
              if (mod_reg == REG_CONV_CTRL) begin
                n.ctrl = wword;
                n.ctrl[CTRL_START_LSB +: 3] = 3'b000;
                // Converter powered off: word kept, nothing started
                if (r.power[PWR_ADC_BIT] && start_req != 3'b000) begin
                  if (start_req[0]) begin
                    sel_chan = CH_ONE;
                  end else if (start_req[1]) begin
                    sel_chan = CH_TWO;
                  end else begin
                    sel_chan = CH_TEMP;
                  end
                  n.ctrl[CTRL_START_LSB + 32'(sel_chan)] = 1'b1;
                  n.state = ST_CONV;
                  n.halt = 1'b1;
                  n.res = r.setup_a[sel_chan][SETUP_A_RES_LSB +: 3];
                  n.conv_cnt = conv_clocks(r.setup_a[sel_chan][SETUP_A_RES_LSB +: 3],
                                           r.setup_b[sel_chan][SETUP_B_BIAS_LSB +: 3]);
                  n.afe.chan = sel_chan;
                  n.afe.bias = r.setup_b[sel_chan][SETUP_B_BIAS_LSB +: 3];
                  n.afe.gain_code = r.setup_a[sel_chan][SETUP_A_GAIN_LSB +: 4];
                  n.afe.gain_mode = GAIN_PROG;
                  n.afe.se_sel = SE_NONE;
                  if (sel_chan == CH_TEMP) begin
                    n.afe.ref_sel = REF_BANDGAP;
                    n.afe.gain_mode = GAIN_FIX_094;
                  end else begin
                    n.afe.se_sel = se_code;
                    if (se_code >= SE_FIX_070_MIN) begin
                      n.afe.gain_mode = GAIN_FIX_070;
                    end else if (se_code >= SE_FIX_094_MIN) begin
                      n.afe.gain_mode = GAIN_FIX_094;
                    end
                    // Bandgap alone is reserved for temperature
                    case (r.setup_b[sel_chan][SETUP_B_REF_LSB +: 2])
                      REF_SUPPLY: begin
                        n.afe.ref_sel = REF_SUPPLY;
                      end
                      REF_EXT_PIN: begin
                        n.afe.ref_sel = REF_EXT_PIN;
                      end
                      default: begin
                        n.afe.ref_sel = REF_BANDGAP_X4;
                      end
                    endcase
                  end
                end
              end
            end
          end
        end
      end

      ST_CONV: begin
        // Processor is halted, so no port access can land here
        if (presc_tick) begin
          if (r.conv_cnt <= 16'h0001) begin
            n.result[r.afe.chan] = r.data_sync & res_mask(r.res);
            n.ctrl[CTRL_START_LSB +: 3] = 3'b000;
            n.halt = 1'b0;
            n.state = ST_IDLE;
            n.conv_cnt = 16'h0000;
          end else begin
            n.conv_cnt = r.conv_cnt - 16'h0001;
          end
        end
      end

      default: begin
        n = SEQ_RST;
      end
    endcase

    n.afe.power = n.power[PWR_ADC_BIT];
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      r <= SEQ_RST;
    end else begin
      r <= n;
    end
  end

  // ************************************************
  // Converter clock
  // ************************************************
  assign presc_run = (r.state == ST_CONV);
  assign presc_div_m1 = r.setup_b[r.afe.chan][SETUP_B_PRESC_LSB +: PRESC_W];

  adcs_prescaler #(
    .DIV_W(PRESC_W)
  ) u_presc (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .run_i(presc_run),
    .div_m1_i(presc_div_m1),
    .tick_o(presc_tick),
    .conv_clk_o(conv_clk_o)
  );

  // ************************************************
  // Outputs
  // ************************************************
  assign port_rdata_o = r.rdata;
  assign dbg_word_o = r.dbg;
  assign cpu_halt_o = r.halt;
  assign cpu_run_o = r.run;
  assign afe_ctl_o = r.afe;

endmodule // adcs_sequencer

`default_nettype wire

// File: verification/adcs_cpu_model.sv
// Processor-side model issuing port accesses to the sequencer
`timescale 1ns/1ps
`default_nettype none

module adcs_cpu_model
  import adcs_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic run_i,
  input wire logic halt_i,
  input wire logic [15:0] rdata_i,
  output var adcs_port_req_t req_o,
  output var adcs_dbg_t dbg_o
);
  initial begin
    req_o = '0;
    dbg_o = '{acc: 16'h1A2B, ptr: 16'h3C4D, instr: 16'h5E6F};
  end

  // ********
  // One word per access, held until taken
  // ********
  task automatic acc(input logic w, input logic r, input logic [3:0] i, input logic [15:0] d,
                     output logic [15:0] q);
    @(negedge core_clk_i);
    req_o = '{wr: w, rd: r, idx: i, wdata: d};
    do @(posedge core_clk_i); while (!(run_i && !halt_i));
    @(negedge core_clk_i);
    req_o.wr = 1'b0;
    req_o.rd = 1'b0;
    // Released data shows no stale word
    req_o.wdata = ~d;
    @(negedge core_clk_i);
    q = rdata_i;
  endtask
endmodule // adcs_cpu_model

`default_nettype wire

// File: verification/adcs_seq_properties.sv
// Port assertions of the converter sequencer
`timescale 1ns/1ps
`default_nettype none

module adcs_seq_properties
  import adcs_pkg::*;
#(
  parameter int POR_HOLD_CYCLES = POR_HOLD_CYC
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire adcs_port_req_t port_req_i,
  input wire adcs_dbg_t dbg_i,
  input wire logic [1:0] dbg_sel_i,
  input wire logic [15:0] conv_data_i,
  input wire logic [15:0] port_rdata_o,
  input wire logic [15:0] dbg_word_o,
  input wire logic cpu_halt_o,
  input wire logic cpu_run_o,
  input wire adcs_afe_ctl_t afe_ctl_o,
  input wire logic conv_clk_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  logic take;
  logic wr_lo;
  logic rd_tk;
  logic start;
  logic pwr_r;
  logic [15:0] addr_r;
  logic [15:0] age_r;
  assign take = cpu_run_o && !cpu_halt_o;
  assign rd_tk = take && port_req_i.rd;
  assign wr_lo = take && port_req_i.wr && port_req_i.idx == PORT_MOD_DATA_LO;
  assign start = wr_lo && addr_r[7:0] == {MOD_ID_ADC, REG_CONV_CTRL} && port_req_i.wdata[2:0] != 3'h0 && pwr_r;

  // ********
  // Mirror of address and power, so start can be predicted
  // ********
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_r <= 16'h0000;
      pwr_r <= 1'b0;
      age_r <= 16'h0000;
    end else begin
      if (age_r != 16'hFFFF) begin
        age_r <= age_r + 16'h0001;
      end
      if (take && port_req_i.wr && port_req_i.idx == PORT_MOD_ADDR) begin
        addr_r <= port_req_i.wdata;
      end
      if (wr_lo && addr_r[7:0] == {MOD_ID_POWER, REG_POWER_CTRL}) begin
        pwr_r <= port_req_i.wdata[PWR_ADC_BIT];
      end
    end
  end

  run_hold_a: assert property (age_r <= POR_HOLD_CYCLES |-> !cpu_run_o)
    else $error("run before hold end");
  run_stays_a: assert property (cpu_run_o |=> cpu_run_o)
    else $error("run dropped");
  halt_run_a: assert property (cpu_halt_o |-> cpu_run_o)
    else $error("halt during hold");
  start_halt_a: assert property (start |=> cpu_halt_o)
    else $error("start did not halt");
  halt_min_a: assert property ($rose(cpu_halt_o) |-> cpu_halt_o [*8])
    else $error("halt too short");
  power_bit_a: assert property (afe_ctl_o.power == pwr_r)
    else $error("power bit wrong");
  afe_hold_a: assert property (cpu_halt_o && $past(cpu_halt_o) |-> $stable(afe_ctl_o))
    else $error("front end moved");
  temp_ref_a: assert property (afe_ctl_o.chan == CH_TEMP |->
    afe_ctl_o.ref_sel == REF_BANDGAP && afe_ctl_o.gain_mode == GAIN_FIX_094)
    else $error("temperature setup wrong");
  rdata_hold_a: assert property (!rd_tk && !$past(rd_tk) |=> $stable(port_rdata_o))
    else $error("read data moved");
  dbg_idle_a: assert property (!cpu_halt_o && !$past(cpu_halt_o) |-> dbg_word_o == 16'h0000)
    else $error("debug word while running");
  dbg_ptr_a: assert property (cpu_halt_o && $past(cpu_halt_o) && $past(dbg_sel_i) == DBG_PTR |->
    dbg_word_o == $past(dbg_i.ptr))
    else $error("debug pointer wrong");
  clk_idle_a: assert property (!cpu_halt_o |-> !conv_clk_o)
    else $error("converter clock while running");
endmodule // adcs_seq_properties

bind adcs_sequencer adcs_seq_properties #(.POR_HOLD_CYCLES(POR_HOLD_CYCLES)) u_props (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .port_req_i(port_req_i), .dbg_i(dbg_i),
  .dbg_sel_i(dbg_sel_i), .conv_data_i(conv_data_i), .port_rdata_o(port_rdata_o),
  .dbg_word_o(dbg_word_o), .cpu_halt_o(cpu_halt_o), .cpu_run_o(cpu_run_o),
  .afe_ctl_o(afe_ctl_o), .conv_clk_o(conv_clk_o));

`default_nettype wire

// File: verification/adcs_sequencer_tb_top.sv
// Self-checking bench of the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); n_mismatch++; end end

module adcs_sequencer_tb_top
  import adcs_pkg::*;
;
  // Short hold keeps the run brief
  localparam int HOLD = 8;
  logic core_clk_i;
  logic rstn_i;
  logic [1:0] dbg_sel_i;
  logic [15:0] conv_data_i;
  adcs_port_req_t port_req;
  adcs_dbg_t dbg;
  logic [15:0] port_rdata_o;
  logic [15:0] dbg_word_o;
  logic cpu_halt_o;
  logic cpu_run_o;
  adcs_afe_ctl_t afe_ctl_o;
  logic conv_clk_o;
  logic [15:0] q;
  int n_mismatch = 0;
  int check_count = 0;
  int clk_rises = 0;

  adcs_sequencer #(.POR_HOLD_CYCLES(HOLD)) u_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .port_req_i(port_req), .dbg_i(dbg), .dbg_sel_i(dbg_sel_i), .conv_data_i(conv_data_i),
    .port_rdata_o(port_rdata_o), .dbg_word_o(dbg_word_o), .cpu_halt_o(cpu_halt_o),
    .cpu_run_o(cpu_run_o), .afe_ctl_o(afe_ctl_o), .conv_clk_o(conv_clk_o));
  adcs_cpu_model u_cpu (.core_clk_i(core_clk_i), .run_i(cpu_run_o), .halt_i(cpu_halt_o),
    .rdata_i(port_rdata_o), .req_o(port_req), .dbg_o(dbg));

  // Converter clock periods seen by the front end
  always @(posedge conv_clk_o) clk_rises++;

  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  // ********
  // Access helpers
  // ********
  task automatic wr(input logic [3:0] i, input logic [15:0] d);
    u_cpu.acc(1'b1, 1'b0, i, d, q);
  endtask
  task automatic mwr(input logic [15:0] a, input logic [15:0] d);
    wr(PORT_MOD_ADDR, a);
    wr(PORT_MOD_DATA_LO, d);
  endtask
  task automatic mrd(input logic [15:0] a);
    wr(PORT_MOD_ADDR, a);
    u_cpu.acc(1'b0, 1'b1, PORT_MOD_DATA_HI, 16'h0000, q);
  endtask

  // ********
  // Scenarios
  // ********
  task automatic por();
    int k;
    @(negedge core_clk_i);
    rstn_i = 1'b0;
    repeat (20) @(negedge core_clk_i);
    `CHK(({port_rdata_o, dbg_word_o, cpu_halt_o, cpu_run_o, afe_ctl_o, conv_clk_o}), 53'h0)
    rstn_i = 1'b1;
    k = 0;
    while (cpu_run_o !== 1'b1 && k < 100) begin
      @(negedge core_clk_i);
      k++;
    end
    `CHK(k >= HOLD + 2 && k <= HOLD + 3, 1'b1)
  endtask

  task automatic t_ports();
    for (int i = 0; i < 13; i++) begin
      wr(i[3:0], 16'h1111 * i[15:0]);
    end
    for (int i = 0; i < 13; i++) begin
      u_cpu.acc(1'b0, 1'b1, i[3:0], 16'h0000, q);
      `CHK(q, 16'h1111 * i[15:0])
    end
  endtask

  task automatic t_refuse();
    mwr(16'h0010, 16'h0001);
    `CHK(cpu_halt_o, 1'b0)
    mrd(16'h0010);
    `CHK(q, 16'h0000)
    mwr(16'h0013, 16'hFFFF);
    mrd(16'h0013);
    `CHK(q, 16'h0000)
    mwr(16'h0000, 16'h0001);
    `CHK(afe_ctl_o.power, 1'b1)
  endtask

  task automatic t_setup();
    // Gain before start; divisor 6 on channel one
    mwr(16'h0011, 16'h0005);
    mwr(16'h0012, 16'h028F);
    mrd(16'h0011);
    `CHK(q, 16'h0005)
    mrd(16'h0012);
    `CHK(q, 16'h028F)
  endtask

  task automatic conv(input logic [15:0] c, input adcs_afe_ctl_t e, input int n, input int nt,
                      input logic [15:0] m, input logic [15:0] a, input logic [15:0] din);
    int k;
    int c0;
    conv_data_i = din;
    c0 = clk_rises;
    mwr(16'h0010, c);
    `CHK(afe_ctl_o, e)
    for (int s = 0; s < 4; s++) begin
      dbg_sel_i = s[1:0];
      @(negedge core_clk_i);
      `CHK(dbg_word_o, s == 0 ? dbg.acc : s == 1 ? dbg.ptr : s == 2 ? dbg.instr : 16'h0000)
    end
    k = 5;
    while (cpu_halt_o === 1'b1 && k < 9000) begin
      @(negedge core_clk_i);
      k++;
    end
    `CHK(k >= n - 2 && k <= n + 4, 1'b1)
    `CHK(clk_rises - c0, nt)
    mrd(a);
    `CHK(q, din & m)
    mrd(16'h0010);
    `CHK(q, c & 16'hFFF8)
  endtask

  task automatic t_convs();
    conv(16'h0001, '{1'b1, CH_ONE, REF_EXT_PIN, GAIN_PROG, 4'h5, 4'h0, 3'h7},
         96, 16, 16'hFF80, 16'h0013, 16'hA5A5);
    conv(16'h0086, '{1'b1, CH_TWO, REF_SUPPLY, GAIN_FIX_094, 4'h0, 4'h8, 3'h0},
         512, 128, 16'hFF80, 16'h0016, 16'h5A5A);
    conv(16'h00C2, '{1'b1, CH_TWO, REF_SUPPLY, GAIN_FIX_070, 4'h0, 4'hC, 3'h0},
         512, 128, 16'hFF80, 16'h0016, 16'h1234);
    conv(16'h0004, '{1'b1, CH_TEMP, REF_BANDGAP, GAIN_FIX_094, 4'h0, 4'h0, 3'h0},
         512, 128, 16'hFF80, 16'h0019, 16'h8001);
    // Twelve bits at full bias, bandgap x4, on channel two
    mwr(16'h0014, 16'h003A);
    mwr(16'h0015, 16'h0017);
    conv(16'h0032, '{1'b1, CH_TWO, REF_BANDGAP_X4, GAIN_PROG, 4'hA, 4'h3, 3'h7},
         512, 128, 16'hFFF0, 16'h0016, 16'h7FFF);
  endtask

  task automatic t_rereset();
    por();
    mrd(16'h0000);
    `CHK(q, 16'h0000)
  endtask

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    rstn_i = 1'b0;
    dbg_sel_i = 2'h0;
    conv_data_i = 16'h0000;
    por();
    t_ports();
    t_refuse();
    t_setup();
    t_convs();
    t_rereset();
    stop_test();
  end

  // Hang guard, well above the expected run
  initial begin
    #(50 * 20000);
    n_mismatch++;
    stop_test();
  end
endmodule // adcs_sequencer_tb_top

`default_nettype wire
